// File: core/output_limit_command_regs.sv
/*
  Paged output limit command bank with warning side effects.
  Assumes a command engine on CLK hands over one whole transfer per
  cycle and that PAGE and the sensed values are on the same clock.
*/
// How it works
// - Droop code times ten gives microvolts per ampere; resets to zero.
// - Droop and overvoltage writes act only after the commit command.
// - Output target is never driven below the minimum target register.
// - Overvoltage threshold, reset 1900 mV, trips the overvoltage fault.
// - Undervoltage fault is masked while ramping or disabled.
// - Stage over-temperature fault limit is signed Celsius, resets to 125.
// - Any temperature above warning limit sets flags, alert and warning pins.
// - Warning limit is signed Celsius, resets to 2000, accepts 0 to 2000.
// - Each limit is paged and moves exactly two data bytes.
// - Target exceeds maximum target only when minimum is above it; maximum also bounds min, OV and UV writes.
`timescale 1ns/1ps

module output_limit_command_regs
  import limit_cmd_pkg::*;
#(
  parameter int NPAGE = 2,
  parameter int NTEMP = 2
) (
  input  wire logic                                  CLK,
  input  wire logic                                  NRST,
  input  wire logic [$clog2(NPAGE)-1:0]              PAGE,
  input  wire bus_req_s                              BUS_REQ,
  output bus_rsp_s                                   BUS_RSP,
  input  wire rail_in_s [NPAGE-1:0]                  RAIL_IN,
  input  wire logic [NPAGE-1:0][NTEMP-1:0][15:0]     TEMP_SENSE,
  input  wire logic                                  WARN_CLEAR,
  output rail_out_s [NPAGE-1:0]                      RAIL_OUT,
  output logic                                       STATUS_TEMP,
  output logic                                       BUS_ALERT_PIN_O,
  output logic                                       BUS_ALERT_PIN_OE,
  output logic                                       THERMAL_WARNING_PIN_O,
  output logic                                       THERMAL_WARNING_PIN_OE
);

  // ==========================================================
  // State
  typedef struct packed {
    page_regs_s [NPAGE-1:0]   regs;
    logic [NPAGE-1:0][15:0]   act_ov;
    rail_out_s [NPAGE-1:0]    out;
    bus_rsp_s                 rsp;
  } state_s;

  state_s                     q;
  state_s                     d;
  field_e                     fld;
  logic                       commit;
  logic [NPAGE-1:0][15:0]     g_target;
  logic [NPAGE-1:0]           g_ov;
  logic [NPAGE-1:0]           g_uv;
  logic [NPAGE-1:0]           g_otf;
  logic [NPAGE-1:0]           g_otw;

  // ==========================================================
  // Decode and field access
  function automatic field_e field_of(input logic [7:0] cmd);
    unique case (cmd)
      CMD_OUT_MAX:  field_of = F_OUT_MAX;
      CMD_DROOP:    field_of = F_DROOP;
      CMD_OUT_MIN:  field_of = F_OUT_MIN;
      CMD_OV_LIMIT: field_of = F_OV;
      CMD_UV_LIMIT: field_of = F_UV;
      CMD_OT_FAULT: field_of = F_OT_FAULT;
      CMD_OT_WARN:  field_of = F_OT_WARN;
      default:      field_of = F_NONE;
    endcase
  endfunction

  function automatic logic [15:0] get_field(input page_regs_s r, input field_e f);
    unique case (f)
      F_OUT_MAX:  get_field = r.out_max;
      F_DROOP:    get_field = r.droop;
      F_OUT_MIN:  get_field = r.out_min;
      F_OV:       get_field = r.ov_limit;
      F_UV:       get_field = r.uv_limit;
      F_OT_FAULT: get_field = r.ot_fault;
      F_OT_WARN:  get_field = r.ot_warn;
      F_NONE:     get_field = 16'h0000;
    endcase
  endfunction

  function automatic page_regs_s set_field(input page_regs_s r, input field_e f,
                                           input logic [15:0] v);
    set_field = r;
    unique case (f)
      F_OUT_MAX:  set_field.out_max = v;
      F_DROOP:    set_field.droop = v;
      F_OUT_MIN:  set_field.out_min = v;
      F_OV:       set_field.ov_limit = v;
      F_UV:       set_field.uv_limit = v;
      F_OT_FAULT: set_field.ot_fault = v;
      F_OT_WARN:  set_field.ot_warn = v;
      F_NONE:     set_field = r;
    endcase
  endfunction

  // Out of range values are refused rather than stored
  function automatic logic value_ok(input page_regs_s r, input field_e f,
                                    input logic [15:0] v);
    unique case (f)
      F_OUT_MIN, F_OV, F_UV:  value_ok = (v <= r.out_max);
      F_OT_FAULT, F_OT_WARN:  value_ok = !v[15] && (v <= TEMP_LIMIT_MAX);
      F_OUT_MAX, F_DROOP:     value_ok = 1'b1;
      F_NONE:                 value_ok = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Per-output guards
  for (genvar p = 0; p < NPAGE; p++) begin : g_rail
    output_guard #(
      .NTEMP (NTEMP)
    ) u_guard (
      .lim     (q.regs[p]),
      .act_ov  (q.act_ov[p]),
      .rail    (RAIL_IN[p]),
      .temps   (TEMP_SENSE[p]),
      .target  (g_target[p]),
      .ov_hit  (g_ov[p]),
      .uv_hit  (g_uv[p]),
      .otf_hit (g_otf[p]),
      .otw_hit (g_otw[p])
    );
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    d.rsp = '0;
    commit = 1'b0;
    fld = field_of(BUS_REQ.cmd);
    if (BUS_REQ.wr) begin
      d.rsp.ack = 1'b1;
      if (BUS_REQ.cmd == CMD_COMMIT && BUS_REQ.nbytes == 2'h0) begin
        commit = 1'b1;
      end else if (fld == F_NONE || BUS_REQ.nbytes != PAYLOAD_BYTES ||
                   !value_ok(q.regs[PAGE], fld, BUS_REQ.wdata)) begin
        d.rsp.err = 1'b1;
      end else begin
        d.regs[PAGE] = set_field(q.regs[PAGE], fld, BUS_REQ.wdata);
      end
    end else if (BUS_REQ.rd) begin
      d.rsp.ack = 1'b1;
      if (fld == F_NONE || BUS_REQ.nbytes != PAYLOAD_BYTES) begin
        d.rsp.err = 1'b1;
      end else begin
        d.rsp.rdata = get_field(q.regs[PAGE], fld);
      end
    end
    for (int p = 0; p < NPAGE; p++) begin
      if (commit) begin
        // Shadow copies keep a half-written pair from reaching the loop
        d.act_ov[p] = q.regs[p].ov_limit;
        d.out[p].droop_uva = 20'(q.regs[p].droop) * DROOP_SCALE;
      end
      d.out[p].target = g_target[p];
      d.out[p].ov_fault = g_ov[p];
      d.out[p].uv_fault = g_uv[p];
      d.out[p].ot_fault = g_otf[p];
      // Sticky; a new crossing beats a clear in the same cycle
      d.out[p].ot_warn = g_otw[p] | (q.out[p].ot_warn & ~WARN_CLEAR);
    end
    if (!NRST) begin
      d = '0;
      for (int p = 0; p < NPAGE; p++) begin
        d.regs[p].out_max = OUT_MAX_RST;
        d.regs[p].droop = DROOP_RST;
        d.regs[p].out_min = OUT_MIN_RST;
        d.regs[p].ov_limit = OV_LIMIT_RST;
        d.regs[p].uv_limit = UV_LIMIT_RST;
        d.regs[p].ot_fault = OT_FAULT_RST;
        d.regs[p].ot_warn = OT_WARN_RST;
        d.act_ov[p] = OV_LIMIT_RST;
      end
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  // ==========================================================
  // Outputs
  always_comb begin
    BUS_RSP = q.rsp;
    RAIL_OUT = q.out;
    STATUS_TEMP = 1'b0;
    for (int p = 0; p < NPAGE; p++) begin
      STATUS_TEMP = STATUS_TEMP | q.out[p].ot_warn;
    end
    // Open-drain, active low: pull low while a warning stands
    BUS_ALERT_PIN_O = 1'b0;
    BUS_ALERT_PIN_OE = STATUS_TEMP;
    THERMAL_WARNING_PIN_O = 1'b0;
    THERMAL_WARNING_PIN_OE = STATUS_TEMP;
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  logic wr_ok;
  assign wr_ok = BUS_REQ.wr && field_of(BUS_REQ.cmd) != F_NONE && BUS_REQ.nbytes == PAYLOAD_BYTES;

  droop_scale_a: assert property (
    commit |=> RAIL_OUT[0].droop_uva == 20'($past(q.regs[0].droop)) * DROOP_SCALE)
    else $error("droop output not code times ten after commit");

  droop_reset_a: assert property (
    $past(!NRST) |-> q.regs[0].droop == DROOP_RST && RAIL_OUT[0].droop_uva == 20'h00000)
    else $error("droop not zero after reset");

  no_early_apply_a: assert property (
    !commit |=> $stable(q.act_ov) && $stable(RAIL_OUT[0].droop_uva))
    else $error("threshold or droop applied without commit");

  commit_apply_a: assert property (
    commit |=> q.act_ov[0] == $past(q.regs[0].ov_limit))
    else $error("commit did not apply overvoltage threshold");

  floor_hold_a: assert property (
    1'b1 |=> RAIL_OUT[0].target >= $past(q.regs[0].out_min))
    else $error("target below minimum");

  ceiling_hold_a: assert property (
    q.regs[0].out_min <= q.regs[0].out_max |=> RAIL_OUT[0].target <= $past(q.regs[0].out_max))
    else $error("target above maximum");

  ov_trip_a: assert property (
    RAIL_IN[0].vout_sense > q.act_ov[0] |=> RAIL_OUT[0].ov_fault)
    else $error("overvoltage not flagged");

  ov_reset_a: assert property (
    $past(!NRST) |-> q.regs[0].ov_limit == OV_LIMIT_RST && q.act_ov[0] == OV_LIMIT_RST)
    else $error("overvoltage threshold reset value wrong");

  uv_mask_a: assert property (
    !RAIL_IN[0].enabled || RAIL_IN[0].ramping |=> !RAIL_OUT[0].uv_fault)
    else $error("undervoltage fault not masked");

  uv_trip_a: assert property (
    RAIL_IN[0].enabled && !RAIL_IN[0].ramping && RAIL_IN[0].vout_sense < q.regs[0].uv_limit
    |=> RAIL_OUT[0].uv_fault)
    else $error("undervoltage not flagged in steady state");

  ot_fault_a: assert property (
    $signed(TEMP_SENSE[0][0]) > $signed(q.regs[0].ot_fault) |=> RAIL_OUT[0].ot_fault)
    else $error("stage over-temperature not flagged");

  warn_set_a: assert property (
    $signed(TEMP_SENSE[0][0]) > $signed(q.regs[0].ot_warn) |=>
    RAIL_OUT[0].ot_warn ##0 STATUS_TEMP && BUS_ALERT_PIN_OE && THERMAL_WARNING_PIN_OE)
    else $error("warning crossing missed flags or pins");

  warn_hold_a: assert property (
    RAIL_OUT[0].ot_warn && !WARN_CLEAR |=> RAIL_OUT[0].ot_warn)
    else $error("warning flag dropped without clear");

  warn_range_a: assert property (
    BUS_REQ.wr && BUS_REQ.cmd == CMD_OT_WARN && BUS_REQ.nbytes == PAYLOAD_BYTES &&
    (BUS_REQ.wdata[15] || BUS_REQ.wdata > TEMP_LIMIT_MAX) |=> BUS_RSP.err && $stable(q.regs))
    else $error("out of range warning limit stored");

  warn_reset_a: assert property (
    $past(!NRST) |-> q.regs[0].ot_warn == OT_WARN_RST && q.regs[0].ot_fault == OT_FAULT_RST)
    else $error("temperature limit reset value wrong");

  two_byte_a: assert property (
    BUS_REQ.wr && BUS_REQ.cmd != CMD_COMMIT && BUS_REQ.nbytes != PAYLOAD_BYTES
    |=> BUS_RSP.ack && BUS_RSP.err && $stable(q.regs))
    else $error("wrong byte count not refused");

  page_iso_a: assert property (
    wr_ok && PAGE == '0 |=> $stable(q.regs[NPAGE-1]))
    else $error("write leaked into unselected page");

  commit_cov: cover property (commit ##1 RAIL_OUT[0].droop_uva != 20'h00000);
  warn_cov: cover property ($rose(BUS_ALERT_PIN_OE));
  uv_cov: cover property (RAIL_OUT[0].uv_fault);
  read_cov: cover property (BUS_REQ.rd ##1 BUS_RSP.ack && !BUS_RSP.err);

endmodule

// File: include/limit_cmd_pkg.sv
/*
  Package for the paged output limit command bank: command codes,
  reset values, scaling figures and the carrier structs.
  Assumes a command engine that hands over whole decoded transfers.
*/
package limit_cmd_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_OUT_MAX     = 8'h24;
  localparam logic [7:0] CMD_DROOP       = 8'h28;
  localparam logic [7:0] CMD_OUT_MIN     = 8'h2B;
  localparam logic [7:0] CMD_OV_LIMIT    = 8'h40;
  localparam logic [7:0] CMD_UV_LIMIT    = 8'h44;
  localparam logic [7:0] CMD_OT_FAULT    = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN     = 8'h51;
  localparam logic [7:0] CMD_COMMIT      = 8'hD8;

  // ==========================================================
  // Reset values
  localparam logic [15:0] OUT_MAX_RST    = 16'h08FC;
  localparam logic [15:0] DROOP_RST      = 16'h0000;
  localparam logic [15:0] OUT_MIN_RST    = 16'h0000;
  localparam logic [15:0] OV_LIMIT_RST   = 16'h076C;
  localparam logic [15:0] UV_LIMIT_RST   = 16'h0000;
  localparam logic [15:0] OT_FAULT_RST   = 16'h007D;
  localparam logic [15:0] OT_WARN_RST    = 16'h07D0;

  // ==========================================================
  // Scaling and ranges
  localparam logic [19:0] DROOP_SCALE    = 20'h0000A;
  localparam logic [15:0] TEMP_LIMIT_MAX = 16'h07D0;
  localparam logic [1:0]  PAYLOAD_BYTES  = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    F_OUT_MAX, F_DROOP, F_OUT_MIN, F_OV, F_UV, F_OT_FAULT, F_OT_WARN, F_NONE
  } field_e;

  typedef struct packed {
    logic [15:0] out_max;
    logic [15:0] droop;
    logic [15:0] out_min;
    logic [15:0] ov_limit;
    logic [15:0] uv_limit;
    logic [15:0] ot_fault;
    logic [15:0] ot_warn;
  } page_regs_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  cmd;
    logic [1:0]  nbytes;
    logic [15:0] wdata;
  } bus_req_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } bus_rsp_s;

  typedef struct packed {
    logic        enabled;
    logic        ramping;
    logic [15:0] vout_sense;
    logic [15:0] req_target;
  } rail_in_s;

  typedef struct packed {
    logic [15:0] target;
    logic [19:0] droop_uva;
    logic        ov_fault;
    logic        uv_fault;
    logic        ot_fault;
    logic        ot_warn;
  } rail_out_s;

endpackage

// File: core/output_guard.sv
/*
  Per-output limit guard: clamps the requested target between the
  floor and ceiling and compares sensed values against the limits.
  Purely combinational; the caller registers every result.
*/
`timescale 1ns/1ps

module output_guard
  import limit_cmd_pkg::*;
#(
  parameter int NTEMP = 2
) (
  input  wire page_regs_s              lim,
  input  wire logic [15:0]             act_ov,
  input  wire rail_in_s                rail,
  input  wire logic [NTEMP-1:0][15:0]  temps,
  output logic [15:0]                  target,
  output logic                         ov_hit,
  output logic                         uv_hit,
  output logic                         otf_hit,
  output logic                         otw_hit
);

  logic [15:0] ceil_v;

  // ==========================================================
  // Clamp and compare
  always_comb begin
    // Ceiling first, floor last, so the floor wins a crossed pair
    ceil_v = (rail.req_target > lim.out_max) ? lim.out_max : rail.req_target;
    target = (ceil_v < lim.out_min) ? lim.out_min : ceil_v;
    ov_hit = rail.vout_sense > act_ov;
    // Ramping or disabled outputs would trip falsely
    uv_hit = rail.enabled && !rail.ramping && (rail.vout_sense < lim.uv_limit);
    otf_hit = 1'b0;
    otw_hit = 1'b0;
    for (int i = 0; i < NTEMP; i++) begin
      if ($signed(temps[i]) > $signed(lim.ot_fault)) begin
        otf_hit = 1'b1;
      end
      if ($signed(temps[i]) > $signed(lim.ot_warn)) begin
        otw_hit = 1'b1;
      end
    end
  end

endmodule

// File: verif/host_model.sv
/*
  Host side model of the limit command bank: one whole word per call.
  Assumes the bench calls its tasks from a single process on clk.
*/
`timescale 1ns/1ps

module host_model
  import limit_cmd_pkg::*;
(
  input  wire logic  clk,
  output bus_req_s   req,
  output logic [0:0] page
);
  // ==========================================================
  // Requests
  initial begin
    req  = '0;
    page = 1'h0;
  end

  // Launch just after an edge; the bench holds the request a full cycle
  task automatic put(input logic w, input logic p, input logic [7:0] c, input logic [1:0] n, input logic [15:0] d);
    @(posedge clk);
    page <= p;
    req  <= '{w, !w, c, n, d};
  endtask

  // Droop and overvoltage settings only act once this follows the changed limits
  task automatic commit();
    put(1'h1, page, CMD_COMMIT, 2'h0, 16'h0000);
  endtask

  // Released lines show inverted junk so stale values never look valid
  task automatic idle();
    @(posedge clk);
    req <= '{1'h0, 1'h0, ~req.cmd, ~req.nbytes, ~req.wdata};
  endtask
endmodule

// File: verif/output_limit_command_regs_tb_top.sv
/*
  Self-checking bench for the paged output limit command bank.
  Assumes NPAGE=2, NTEMP=2 and the host model for bus traffic.
*/
`timescale 1ns/1ps

module output_limit_command_regs_tb_top
  import limit_cmd_pkg::*;
;
  typedef struct packed {
    logic        has_rd;
    logic        err;
    logic [15:0] rd;
  } note_s;

  logic                  clk;
  logic                  nrst;
  logic [0:0]            page;
  bus_req_s              bus_req;
  bus_rsp_s              bus_rsp;
  rail_in_s [1:0]        rail_in;
  rail_out_s [1:0]       rail_out;
  logic [1:0][1:0][15:0] temps;
  logic                  warn_clr;
  logic                  stat_temp;
  logic                  alrt_o;
  logic                  alrt_oe;
  logic                  thermal_warning_pin_o;
  logic                  thermal_warning_pin_oe;
  int                    err_total = 0;
  int                    check_count = 0;
  note_s                 q [$];
  logic [31:0]           seed = 32'h00000027;
  logic [15:0]           d;
  logic [7:0]            cmds [7] = '{CMD_OUT_MAX, CMD_DROOP, CMD_OUT_MIN, CMD_OV_LIMIT, CMD_UV_LIMIT,
                                      CMD_OT_FAULT, CMD_OT_WARN};
  logic [15:0]           rsts [7] = '{OUT_MAX_RST, DROOP_RST, OUT_MIN_RST, OV_LIMIT_RST, UV_LIMIT_RST,
                                      OT_FAULT_RST, OT_WARN_RST};

  // ==========================================================
  // Instances
  host_model u_host_model (
    .clk  (clk),
    .req  (bus_req),
    .page (page)
  );

  output_limit_command_regs #(
    .NPAGE (2),
    .NTEMP (2)
  ) u_output_limit_command_regs (
    .CLK                    (clk),
    .NRST                   (nrst),
    .PAGE                   (page),
    .BUS_REQ                (bus_req),
    .BUS_RSP                (bus_rsp),
    .RAIL_IN                (rail_in),
    .TEMP_SENSE             (temps),
    .WARN_CLEAR             (warn_clr),
    .RAIL_OUT               (rail_out),
    .STATUS_TEMP            (stat_temp),
    .BUS_ALERT_PIN_O        (alrt_o),
    .BUS_ALERT_PIN_OE       (alrt_oe),
    .THERMAL_WARNING_PIN_O  (thermal_warning_pin_o),
    .THERMAL_WARNING_PIN_OE (thermal_warning_pin_oe)
  );

  // ==========================================================
  // Helpers
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic op(input logic w, input logic p, input logic [7:0] c, input logic [1:0] n,
                    input logic [15:0] dat, input logic e, input logic [15:0] r);
    q.push_back('{!w, e, r});
    u_host_model.put(w, p, c, n, dat);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic set_rail(input int p, input logic en, input logic rp, input logic [15:0] s, input logic [15:0] t);
    @(posedge clk);
    rail_in[p] <= '{en, rp, s, t};
    settle();
  endtask

  task automatic set_temp(input int p, input int i, input logic [15:0] v);
    @(posedge clk);
    temps[p][i] <= v;
    settle();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Response monitor: ack stands one cycle, so each edge is looked at
  always @(posedge clk) begin
    if (bus_rsp.ack === 1'h1) begin
      if (q.size() == 0) begin
        chk("spurious ack", 20'h1, 20'h0);
      end else begin
        chk("bus err", bus_rsp.err, q[0].err);
        if (q[0].has_rd) chk("read data", bus_rsp.rdata, q[0].rd);
        void'(q.pop_front());
      end
    end
  end

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    close_out();
  end

  // ==========================================================
  // Scenarios
  initial begin
    nrst       = 1'h0;
    warn_clr   = 1'h0;
    rail_in[0] = '{1'h1, 1'h0, 16'h0000, 16'h0100};
    rail_in[1] = '{1'h1, 1'h0, 16'h0300, 16'h0100};
    temps      = {16'h0020, 16'h0020, 16'h0020, 16'hFF00};
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 7; i++)
        op(1'h0, p[0], cmds[i], 2'h2, rnd(), 1'h0, rsts[i]);
    d = rnd();
    op(1'h1, 1'h0, CMD_DROOP, 2'h2, d, 1'h0, 16'h0000);
    op(1'h0, 1'h1, CMD_DROOP, 2'h2, 16'h0000, 1'h0, 16'h0000);
    op(1'h0, 1'h0, CMD_DROOP, 2'h2, 16'h0000, 1'h0, d);
    op(1'h1, 1'h0, CMD_OV_LIMIT, 2'h2, 16'h0700, 1'h0, 16'h0000);
    u_host_model.idle();
    set_rail(0, 1'h1, 1'h0, 16'h0701, 16'h0100);
    chk("ov before commit", rail_out[0].ov_fault, 1'h0);
    chk("droop before commit", rail_out[0].droop_uva, 20'h0);
    q.push_back('{1'h0, 1'h0, 16'h0000});
    u_host_model.commit();
    u_host_model.idle();
    settle();
    chk("ov after commit", rail_out[0].ov_fault, 1'h1);
    chk("droop after commit", rail_out[0].droop_uva, {4'h0, d} * 20'h0000A);
    chk("other page droop", rail_out[1].droop_uva, 20'h0);
    set_rail(0, 1'h1, 1'h0, 16'h0700, 16'h0100);
    chk("ov at threshold", rail_out[0].ov_fault, 1'h0);
    // Refusals leave the stored words untouched
    op(1'h1, 1'h0, CMD_OUT_MAX, 2'h2, 16'h0800, 1'h0, 16'h0000);
    op(1'h1, 1'h0, CMD_OUT_MIN, 2'h2, 16'h0200, 1'h0, 16'h0000);
    op(1'h1, 1'h0, CMD_OV_LIMIT, 2'h2, 16'h0801, 1'h1, 16'h0000);
    op(1'h1, 1'h0, CMD_DROOP, 2'h1, 16'h1234, 1'h1, 16'h0000);
    op(1'h0, 1'h0, CMD_OT_WARN, 2'h3, 16'h0000, 1'h1, 16'h0000);
    op(1'h1, 1'h0, CMD_OT_WARN, 2'h2, 16'hFFFF, 1'h1, 16'h0000);
    op(1'h1, 1'h0, CMD_OT_FAULT, 2'h2, 16'h07D1, 1'h1, 16'h0000);
    op(1'h1, 1'h0, 8'h30, 2'h2, 16'h0000, 1'h1, 16'h0000);
    op(1'h0, 1'h0, CMD_COMMIT, 2'h0, 16'h0000, 1'h1, 16'h0000);
    op(1'h0, 1'h0, CMD_OV_LIMIT, 2'h2, 16'h0000, 1'h0, 16'h0700);
    op(1'h0, 1'h1, CMD_DROOP, 2'h2, 16'h0000, 1'h0, 16'h0000);
    op(1'h1, 1'h0, CMD_UV_LIMIT, 2'h2, 16'h0100, 1'h0, 16'h0000);
    u_host_model.idle();
    set_rail(0, 1'h1, 1'h0, 16'h0500, 16'h0100);
    chk("target floor", rail_out[0].target, 16'h0200);
    set_rail(0, 1'h1, 1'h0, 16'h0500, 16'h0900);
    chk("target ceiling", rail_out[0].target, 16'h0800);
    d = 16'h0200 + (rnd() & 16'h03FF);
    set_rail(0, 1'h1, 1'h0, 16'h0500, d);
    chk("target pass", rail_out[0].target, d);
    set_rail(0, 1'h1, 1'h0, 16'h00FF, 16'h0100);
    chk("uv steady", rail_out[0].uv_fault, 1'h1);
    chk("other page uv", rail_out[1].uv_fault, 1'h0);
    set_rail(0, 1'h1, 1'h1, 16'h00FF, 16'h0100);
    chk("uv ramping", rail_out[0].uv_fault, 1'h0);
    set_rail(0, 1'h0, 1'h0, 16'h00FF, 16'h0100);
    chk("uv disabled", rail_out[0].uv_fault, 1'h0);
    // Warning path: a negative reading must not count as hot
    op(1'h1, 1'h0, CMD_OT_WARN, 2'h2, 16'h0050, 1'h0, 16'h0000);
    u_host_model.idle();
    settle();
    chk("warn idle", stat_temp, 1'h0);
    set_temp(0, 1, 16'h0051);
    chk("warn flag", rail_out[0].ot_warn, 1'h1);
    chk("warn pins", {alrt_o, alrt_oe, thermal_warning_pin_o, thermal_warning_pin_oe, stat_temp}, 5'h0B);
    chk("other page warn", rail_out[1].ot_warn, 1'h0);
    set_temp(0, 1, 16'h0050);
    chk("warn sticky", stat_temp, 1'h1);
    @(posedge clk);
    warn_clr <= 1'h1;
    @(posedge clk);
    warn_clr <= 1'h0;
    settle();
    chk("warn cleared", {alrt_oe, thermal_warning_pin_oe, stat_temp}, 3'h0);
    set_temp(0, 0, 16'h007E);
    chk("stage fault", rail_out[0].ot_fault, 1'h1);
    set_temp(0, 0, 16'h007D);
    chk("stage fault limit", rail_out[0].ot_fault, 1'h0);
    chk("pending notes", 20'(q.size()), 20'h0);
    close_out();
  end
endmodule
